// ---- src/board_control_command_list_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module board_control_command_list_ctrl import bcc_pkg::*; #(
  parameter logic [7:0] FW_REV = 8'h01, // arbitrary firmware level
  parameter logic [7:0] ENG_REV = 8'h01 // arbitrary engineering level
) (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic cmdValid, // parameter block offered
  output logic cmdReady, // block taken when valid
  input wire logic [31:0] cmdIdent, // command identifier
  input wire logic [7:0] cmdAdapterId, // identifier field
  input wire logic [7:0] cmdCode, // command code
  input wire logic [31:0] cmdListAddr, // word at 08H
  input wire logic [7:0] cmdAddrMod, // address modifier byte
  input wire logic [15:0] cmdIntField, // interrupt field
  output logic passStart, // pass-through handoff pulse
  output logic execStart, // other board command pulse
  output logic [7:0] execCode, // code for executor
  input wire logic execDone, // executor finished
  input wire logic [7:0] execErrCode, // executor error, 0 ok
  input wire logic listPending, // commands left in list
  output logic listRunning, // list operation active
  output logic listEnqOk, // list may take new entries
  output logic [31:0] listAddr, // list base address
  output logic [7:0] listAddrMod, // modifier for list access
  output logic statusValid, // status block pulse
  output logic [31:0] statusIdent, // echoed identifier
  output logic [7:0] statusFlags, // completion flags byte
  output logic [7:0] statusError, // error code byte
  output logic statusIdentify, // identify layout selected
  output logic [7:0] statusFwRev, // firmware revision
  output logic [7:0] statusEngRev, // engineering revision
  output logic [2:0] irqLevel, // requested level, 0 none
  input wire logic iackValid, // acknowledge cycle pulse
  input wire logic [2:0] iackLevel, // level being acknowledged
  output logic iackHit, // vector returned pulse
  output logic [7:0] interruptVectorByte // vector on acknowledge
);
  cmd_kind_t kind;
  ctl_state_t state_ff;
  logic running_ff, stopping_ff, irqPend_ff;
  logic [31:0] heldIdent_ff;
  logic [2:0] lvl_ff;
  logic [7:0] vec_ff;
  logic take, finish;
  logic [7:0] finErr;
  default clocking cb_main @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  function automatic logic [7:0] mkFlags(input logic err);
    logic [7:0] f;
    f = 8'h00;
    f[`BCC_FLAG_DONE_BIT] = 1'b1;
    f[`BCC_FLAG_ERR_BIT] = err;
    return f; // other bits stay zero
  endfunction

  board_cmd_decode #(.CODE_W(8)) u_dec (
    .adapterId(cmdAdapterId),
    .cmdCode(cmdCode),
    .kind(kind)
  );

  // one block at a time; drain and exec waits hold off new blocks
  assign cmdReady = (state_ff == ST_IDLE);
  assign take = cmdValid && cmdReady;
  assign listRunning = running_ff;
  assign listEnqOk = running_ff && !stopping_ff;
  assign irqLevel = irqPend_ff ? lvl_ff : `BCC_LVL_OFF;

  // immediate completion of the taken block, or of a waited one
  always_comb begin
    finish = 1'b0;
    finErr = `BCC_ERR_NONE;
    if (take) begin
      unique case (kind)
        KIND_START: begin
          finish = 1'b1;
          if (running_ff) begin
            finErr = `BCC_ERR_LIST_STATE;
          end else if (cmdIntField[`BCC_INT_RSV_HI:`BCC_INT_RSV_LO] != 5'h0) begin
            finErr = `BCC_ERR_BAD_INT;
          end
        end
        KIND_STOP: begin
          finish = !running_ff;
          finErr = `BCC_ERR_LIST_STATE;
        end
        KIND_IDENTIFY: finish = 1'b1;
        KIND_BAD_CODE: begin
          finish = 1'b1;
          finErr = `BCC_ERR_BAD_CODE;
        end
        KIND_BAD_ID: begin
          finish = 1'b1;
          finErr = `BCC_ERR_BAD_ID;
        end
        KIND_PASS, KIND_OTHER: finish = 1'b0;
      endcase
    end else if (state_ff == ST_DRAIN) begin
      finish = !listPending;
    end else if (state_ff == ST_EXEC) begin
      finish = execDone;
      finErr = execErrCode;
    end
  end

  // sequencing of stop drains and delegated commands
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else if (take && kind == KIND_STOP && running_ff) begin
      state_ff <= ST_DRAIN;
    end else if (take && kind == KIND_OTHER) begin
      state_ff <= ST_EXEC;
    end else if (state_ff != ST_IDLE && finish) begin
      state_ff <= ST_IDLE;
    end
  end

  // list run state; stopping blocks the queue until drained
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      running_ff <= 1'b0;
      stopping_ff <= 1'b0;
    end else if (take && kind == KIND_START && finErr == `BCC_ERR_NONE) begin
      running_ff <= 1'b1;
    end else if (take && kind == KIND_STOP && running_ff) begin
      stopping_ff <= 1'b1;
    end else if (state_ff == ST_DRAIN && finish) begin
      running_ff <= 1'b0;
      stopping_ff <= 1'b0;
    end
  end

  // list location, modifier and interrupt setup captured on start
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      listAddr <= 32'h0000_0000;
      listAddrMod <= 8'h00;
      lvl_ff <= `BCC_LVL_OFF;
      vec_ff <= 8'h00;
    end else if (take && kind == KIND_START && finErr == `BCC_ERR_NONE) begin
      listAddr <= cmdListAddr;
      listAddrMod <= cmdAddrMod;
      lvl_ff <= cmdIntField[`BCC_INT_LVL_HI:`BCC_INT_LVL_LO];
      vec_ff <= cmdIntField[`BCC_INT_VEC_HI:`BCC_INT_VEC_LO];
    end
  end

  // identifier of a block whose status is deferred
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      heldIdent_ff <= 32'h0000_0000;
    end else if (take) begin
      heldIdent_ff <= cmdIdent;
    end
  end

  // handoff pulses
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      passStart <= 1'b0;
      execStart <= 1'b0;
      execCode <= 8'h00;
    end else begin
      passStart <= take && kind == KIND_PASS;
      execStart <= take && kind == KIND_OTHER;
      if (take) begin
        execCode <= cmdCode;
      end
    end
  end

  // status block, registered so every field lines up with the pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      statusValid <= 1'b0;
      statusIdent <= 32'h0000_0000;
      statusFlags <= 8'h00;
      statusError <= 8'h00;
      statusIdentify <= 1'b0;
    end else begin
      statusValid <= finish;
      if (finish) begin
        statusIdent <= take ? cmdIdent : heldIdent_ff;
        statusFlags <= mkFlags(finErr != `BCC_ERR_NONE);
        statusError <= finErr;
        statusIdentify <= take && kind == KIND_IDENTIFY;
      end
    end
  end
  assign statusFwRev = FW_REV;
  assign statusEngRev = ENG_REV;

  // completion interrupt; a new completion beats a same-cycle acknowledge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqPend_ff <= 1'b0;
    end else if (statusValid && lvl_ff != `BCC_LVL_OFF) begin
      irqPend_ff <= 1'b1;
    end else if (iackValid && iackLevel == lvl_ff) begin
      irqPend_ff <= 1'b0;
    end
  end

  // vector answer registered, one cycle after the acknowledge pulse
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      iackHit <= 1'b0;
      interruptVectorByte <= 8'h00;
    end else begin
      iackHit <= iackValid && irqPend_ff && iackLevel == lvl_ff;
      if (iackValid && irqPend_ff && iackLevel == lvl_ff) begin
        interruptVectorByte <= vec_ff;
      end
    end
  end

  // checks share the clocking and reset declared at the top
  property p_start_busy;
    take && kind == KIND_START && running_ff |=> statusValid && statusError == 8'h11;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start busy not 11H");
  property p_stop_idle;
    take && kind == KIND_STOP && !running_ff
      |=> statusValid && statusFlags == 8'hc0 && statusError == 8'h11;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop idle not 11H");
  property p_stop_waits;
    state_ff == ST_DRAIN && listPending |=> !statusValid;
  endproperty
  a_stop_waits: assert property (p_stop_waits) else $error("stop status early");
  property p_enq_block;
    take && kind == KIND_STOP && running_ff |=> !listEnqOk && listRunning;
  endproperty
  a_enq_block: assert property (p_enq_block) else $error("queue open after stop");
  property p_flags;
    statusValid |-> statusFlags[7] && statusFlags[5:0] == 6'h0
      && statusFlags[6] == (statusError != 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("flags byte malformed");
  property p_capture;
    take && kind == KIND_START && !running_ff && cmdIntField[15:11] == 5'h0
      |=> listAddr == $past(cmdListAddr) && listAddrMod == $past(cmdAddrMod) && listRunning;
  endproperty
  a_capture: assert property (p_capture) else $error("list setup not captured");
  property p_vector;
    iackHit |-> interruptVectorByte == vec_ff;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector returned");
  property p_iack_miss;
    iackValid && iackLevel != irqLevel |=> !iackHit;
  endproperty
  a_iack_miss: assert property (p_iack_miss) else $error("wrong level answered");
  property p_lvl_off;
    lvl_ff == 3'h0 |-> irqLevel == 3'h0;
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("irq while disabled");
  property p_badcode;
    take && kind == KIND_BAD_CODE |=> statusValid && statusFlags[6] && statusError == 8'h20;
  endproperty
  a_badcode: assert property (p_badcode) else $error("bad code not failed");
  property p_pass;
    take && cmdAdapterId <= 8'h0f |=> passStart && !statusValid;
  endproperty
  a_pass: assert property (p_pass) else $error("pass-through not handed off");

  c_start: cover property (take && kind == KIND_START ##1 listRunning);
  c_drain: cover property (state_ff == ST_DRAIN ##[1:20] statusValid);
  c_iack: cover property (iackHit);
  c_ident: cover property (statusValid && statusIdentify);
endmodule
`default_nettype wire

// ---- src/bcc_consts.svh ----
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH
// identifier field values
`define BCC_ID_BOARD 8'hff
`define BCC_ID_PASS_MAX 8'h0f
// board-control command codes
`define BCC_OP_START 8'h01
`define BCC_OP_STOP 8'h02
`define BCC_OP_IDENTIFY 8'h05
`define BCC_OP_STATS 8'h06
`define BCC_OP_GEN_OPT 8'h07
`define BCC_OP_UNIT_OPT 8'h08
`define BCC_OP_DIAG 8'h09
`define BCC_OP_TGT_EN 8'h0a
`define BCC_OP_TGT_DIS 8'h0b
`define BCC_OP_ABORT 8'h0d
`define BCC_OP_HARD_RST 8'h10
`define BCC_OP_BRD_INFO 8'h15
`define BCC_OP_EXT_STATS 8'h16
`define BCC_OP_EXT_UNIT 8'h18
// error codes
`define BCC_ERR_NONE 8'h00
`define BCC_ERR_LIST_STATE 8'h11
`define BCC_ERR_BAD_CODE 8'h20
`define BCC_ERR_BAD_ID 8'h21
`define BCC_ERR_BAD_INT 8'h22
// completion flags byte
`define BCC_FLAG_DONE_BIT 7
`define BCC_FLAG_ERR_BIT 6
// interrupt field layout
`define BCC_INT_RSV_HI 15
`define BCC_INT_RSV_LO 11
`define BCC_INT_LVL_HI 10
`define BCC_INT_LVL_LO 8
`define BCC_INT_VEC_HI 7
`define BCC_INT_VEC_LO 0
`define BCC_LVL_OFF 3'h0
`endif

// ---- src/bcc_pkg.sv ----
package bcc_pkg;
  typedef enum logic [2:0] {
    KIND_PASS, KIND_START, KIND_STOP, KIND_IDENTIFY, KIND_OTHER, KIND_BAD_CODE, KIND_BAD_ID
  } cmd_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_EXEC} ctl_state_t;
endpackage

// ---- src/board_cmd_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module board_cmd_decode import bcc_pkg::*; #(
  parameter int CODE_W = 8
) (
  input wire logic [CODE_W-1:0] adapterId, // identifier field
  input wire logic [CODE_W-1:0] cmdCode, // command code field
  output cmd_kind_t kind // classified command
);
  if (CODE_W != 8) begin : g_chk
    $error("board_cmd_decode: CODE_W must be 8");
  end

  // identifier picks pass-through or board control, code picks operation
  always_comb begin
    if (adapterId <= `BCC_ID_PASS_MAX) begin
      kind = KIND_PASS;
    end else if (adapterId != `BCC_ID_BOARD) begin
      kind = KIND_BAD_ID;
    end else begin
      unique case (cmdCode)
        `BCC_OP_START: kind = KIND_START;
        `BCC_OP_STOP: kind = KIND_STOP;
        `BCC_OP_IDENTIFY: kind = KIND_IDENTIFY;
        `BCC_OP_STATS, `BCC_OP_GEN_OPT, `BCC_OP_UNIT_OPT, `BCC_OP_DIAG,
        `BCC_OP_TGT_EN, `BCC_OP_TGT_DIS, `BCC_OP_ABORT, `BCC_OP_HARD_RST,
        `BCC_OP_BRD_INFO, `BCC_OP_EXT_STATS, `BCC_OP_EXT_UNIT: kind = KIND_OTHER;
        default: kind = KIND_BAD_CODE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/exec_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
// executor stand-in: finishes each hand-off after a set delay
module exec_partner (
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic execStart, // hand-off pulse
  input wire logic [7:0] delay, // cycles to finish
  input wire logic [7:0] errSet, // code to report
  output logic execDone, // finish pulse
  output logic [7:0] execErrCode // valid only with done
);
  logic busy_ff;
  logic [7:0] cnt_ff;
  // one job in flight, so a single counter is enough
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      execDone <= 1'b0;
    end else begin
      // done is written once per edge so it never glitches
      execDone <= !execStart && busy_ff && cnt_ff == 8'h00;
      if (execStart) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
  // off the done pulse the code is junk, so a design reading it late is caught
  assign execErrCode = execDone ? errSet : ~errSet;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcc_consts.svh"
module tb_top import bcc_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset_n, cmdValid, cmdReady, passStart, execStart, execDone, listPending;
  logic listRunning, listEnqOk, statusValid, statusIdentify, iackValid, iackHit;
  logic [31:0] cmdIdent, cmdListAddr, listAddr, statusIdent, idc;
  logic [7:0] cmdAdapterId, cmdCode, cmdAddrMod, execCode, execErrCode, listAddrMod;
  logic [7:0] statusFlags, statusError, statusFwRev, statusEngRev, interruptVectorByte;
  logic [7:0] delay, errSet, eCode;
  logic [15:0] cmdIntField;
  logic [2:0] irqLevel, iackLevel;
  logic pStart, eStart, hit;
  int errors = 0;
  int cmp_count = 0;
  localparam logic [7:0] EXC [0:10] = '{`BCC_OP_STATS, `BCC_OP_GEN_OPT, `BCC_OP_UNIT_OPT,
    `BCC_OP_DIAG, `BCC_OP_TGT_EN, `BCC_OP_TGT_DIS, `BCC_OP_ABORT, `BCC_OP_HARD_RST,
    `BCC_OP_BRD_INFO, `BCC_OP_EXT_STATS, `BCC_OP_EXT_UNIT};

  always #5 ref_clk = ~ref_clk;

  board_control_command_list_ctrl #(.FW_REV(8'h5c), .ENG_REV(8'h3e))
    board_control_command_list_ctrl_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdIdent(cmdIdent), .cmdAdapterId(cmdAdapterId), .cmdCode(cmdCode),
    .cmdListAddr(cmdListAddr), .cmdAddrMod(cmdAddrMod), .cmdIntField(cmdIntField),
    .passStart(passStart), .execStart(execStart), .execCode(execCode), .execDone(execDone),
    .execErrCode(execErrCode), .listPending(listPending), .listRunning(listRunning),
    .listEnqOk(listEnqOk), .listAddr(listAddr), .listAddrMod(listAddrMod),
    .statusValid(statusValid), .statusIdent(statusIdent), .statusFlags(statusFlags),
    .statusError(statusError), .statusIdentify(statusIdentify), .statusFwRev(statusFwRev),
    .statusEngRev(statusEngRev), .irqLevel(irqLevel), .iackValid(iackValid),
    .iackLevel(iackLevel), .iackHit(iackHit), .interruptVectorByte(interruptVectorByte));

  exec_partner exec_partner_i (.ref_clk(ref_clk), .reset_n(reset_n), .execStart(execStart),
    .delay(delay), .errSet(errSet), .execDone(execDone), .execErrCode(execErrCode));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    errors++;
    $display("BAD %0t no answer: %s", $time, what);
    final_report();
  endtask

  // each block gets a fresh identifier; list fields derive from it
  task automatic send(input logic [7:0] adp, input logic [7:0] code, input logic [15:0] intf);
    int i;
    @(negedge ref_clk);
    idc = idc + 32'h0000_0101;
    cmdIdent = idc;
    cmdAdapterId = adp;
    cmdCode = code;
    cmdIntField = intf;
    cmdListAddr = ~idc;
    cmdAddrMod = idc[7:0] ^ 8'h3d;
    cmdValid = 1'b1;
    for (i = 0; i < 20 && cmdReady !== 1'b1; i++) @(negedge ref_clk);
    if (i == 20) hang("ready");
    @(negedge ref_clk);
    cmdValid = 1'b0;
    // fields go stale once taken, so show their inverse; adapter id and modifier keep their values
    cmdIdent = ~idc;
    cmdCode = ~code;
    cmdListAddr = idc;
    cmdIntField = ~intf;
    pStart = passStart;
    eStart = execStart;
    eCode = execCode;
  endtask

  task automatic stat(input logic [7:0] flags, input logic [7:0] err);
    int i;
    for (i = 0; i < 30 && statusValid !== 1'b1; i++) @(negedge ref_clk);
    if (i == 30) hang("status");
    chk(statusIdent, idc, "ident echo");
    chk(statusFlags, flags, "flags");
    chk(statusError, err, "error code");
  endtask

  task automatic iack(input logic [2:0] lvl);
    @(negedge ref_clk);
    iackValid = 1'b1;
    iackLevel = lvl;
    @(negedge ref_clk);
    iackValid = 1'b0;
    iackLevel = ~lvl;
    hit = iackHit;
  endtask

  initial begin
    logic [31:0] savedAddr;
    reset_n = 1'b0;
    {cmdValid, listPending, iackValid, iackLevel} = '0;
    {cmdIdent, cmdAdapterId, cmdCode, cmdListAddr, cmdAddrMod, cmdIntField} = '0;
    idc = 32'h1000_0000;
    delay = 8'h02;
    errSet = 8'h00;
    repeat (16) @(negedge ref_clk);
    chk(cmdReady, 1, "ready in reset");
    chk({listRunning, statusValid, irqLevel}, 0, "idle in reset");
    reset_n = 1'b1;
    $display("test reset done");
    // stop with no list running, unknown code, foreign identifier
    send(`BCC_ID_BOARD, `BCC_OP_STOP, 16'h0000);
    stat(8'hc0, `BCC_ERR_LIST_STATE);
    send(`BCC_ID_BOARD, 8'h03, 16'h0000);
    stat(8'hc0, `BCC_ERR_BAD_CODE);
    send(8'h10, `BCC_OP_STATS, 16'h0000);
    stat(8'hc0, `BCC_ERR_BAD_ID);
    send(8'h00, `BCC_OP_STATS, 16'h0000);
    chk({pStart, eStart}, 2'b10, "pass id 0");
    send(`BCC_ID_PASS_MAX, `BCC_OP_STATS, 16'h0000);
    chk({pStart, eStart}, 2'b10, "pass id 15");
    $display("test errors done");
    // every executor code, one finishing with an error
    for (int k = 0; k < 11; k++) begin
      errSet = (k == 3) ? 8'h33 : 8'h00;
      send(`BCC_ID_BOARD, EXC[k], 16'h0000);
      chk({eStart, eCode}, {1'b1, EXC[k]}, "exec hand-off");
      stat((k == 3) ? 8'hc0 : 8'h80, errSet);
      chk(statusIdentify, 0, "plain layout");
    end
    send(`BCC_ID_BOARD, `BCC_OP_IDENTIFY, 16'h0000);
    stat(8'h80, 8'h00);
    chk({statusIdentify, statusFwRev, statusEngRev}, 17'h1_5c3e, "identify");
    chk(irqLevel, 0, "no level yet");
    $display("test codes done");
    // start: bad reserved bits, then good, then interrupt path
    send(`BCC_ID_BOARD, `BCC_OP_START, 16'h0b5a);
    stat(8'hc0, `BCC_ERR_BAD_INT);
    chk(listRunning, 0, "not started");
    send(`BCC_ID_BOARD, `BCC_OP_START, 16'h03a5);
    stat(8'h80, 8'h00);
    savedAddr = ~idc;
    chk(listRunning, 1, "running");
    chk(listAddr, savedAddr, "list address");
    chk(listAddrMod, idc[7:0] ^ 8'h3d, "modifier");
    repeat (2) @(negedge ref_clk);
    chk(irqLevel, 3, "level 3");
    iack(3'd2);
    chk({hit, irqLevel}, 4'h3, "wrong level ignored");
    iack(3'd3);
    chk({hit, interruptVectorByte}, 9'h1a5, "vector");
    @(negedge ref_clk);
    chk(irqLevel, 0, "cleared");
    // second start while running
    send(`BCC_ID_BOARD, `BCC_OP_START, 16'h0000);
    stat(8'hc0, `BCC_ERR_LIST_STATE);
    chk({listRunning, listEnqOk}, 2'b11, "still running");
    chk(listAddr, savedAddr, "address kept");
    repeat (2) @(negedge ref_clk);
    iack(3'd3);
    $display("test start done");
    // stop must wait for the list to drain
    listPending = 1'b1;
    send(`BCC_ID_BOARD, `BCC_OP_STOP, 16'h0000);
    chk({listEnqOk, cmdReady}, 2'b00, "queue closed");
    repeat (5) begin
      @(negedge ref_clk);
      chk(statusValid, 0, "stop held");
    end
    listPending = 1'b0;
    stat(8'h80, 8'h00);
    @(negedge ref_clk);
    chk(listRunning, 0, "stopped");
    repeat (2) @(negedge ref_clk);
    iack(3'd3);
    $display("test stop done");
    // level zero means no interrupt
    send(`BCC_ID_BOARD, `BCC_OP_START, 16'h0077);
    stat(8'h80, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(irqLevel, 0, "disabled");
    send(`BCC_ID_BOARD, `BCC_OP_STOP, 16'h0000);
    stat(8'h80, 8'h00);
    $display("test level zero done");
    final_report();
  end
endmodule
`default_nettype wire
